/* verilog/fsq_defs.svh */
// Constants for the flash command sequencer host controller
`ifndef FSQ_DEFS_SVH
`define FSQ_DEFS_SVH
// ----------------------------------------------------------------
// Flash command codes
// ----------------------------------------------------------------
`define FSQ_CMD_READ_ARRAY 8'hff
`define FSQ_CMD_READ_STATUS 8'h70
`define FSQ_CMD_CLEAR_STATUS 8'h50
`define FSQ_CMD_PROGRAM 8'h40
`define FSQ_CMD_PROGRAM_ALT 8'h10
`define FSQ_CMD_BUF_SETUP 8'he8
`define FSQ_CMD_CONFIRM 8'hd0
`define FSQ_CMD_SUSPEND 8'hb0
`define FSQ_CMD_RESUME 8'hd0
`define FSQ_CMD_SET_READ_CFG 8'h60
// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define FSQ_SR_READY 7
`define FSQ_SR_ERASE_SUSP 6
`define FSQ_SR_ERASE_ERR 5
`define FSQ_SR_PROG_ERR 4
`define FSQ_SR_LOW_VOLT 3
`define FSQ_SR_PROG_SUSP 2
`define FSQ_SR_LOCK_ABORT 1
`define FSQ_XSR_BUF_AVAIL 7
// ----------------------------------------------------------------
// Host register offsets
// ----------------------------------------------------------------
`define FSQ_REG_CMD 4'h0
`define FSQ_REG_ADDR 4'h1
`define FSQ_REG_DATA 4'h2
`define FSQ_REG_COUNT 4'h3
`define FSQ_REG_STATUS 4'h4
`define FSQ_REG_FLASH_SR 4'h5
`define FSQ_REG_RDATA 4'h6
// ----------------------------------------------------------------
// Bus timing
// ----------------------------------------------------------------
`define FSQ_T_PULSE_NS 200
`define FSQ_CLK_NS 100
`define FSQ_PULSE_CYC ((`FSQ_T_PULSE_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`endif

/* verilog/fsq_pkg.sv */
// Types for the flash command sequencer host controller
package fsq_pkg;
  // Host operation requested through the command register
  typedef enum logic [3:0] {
    fsq_op_none = 4'h0,
    fsq_op_program = 4'h1,
    fsq_op_buffer = 4'h2,
    fsq_op_erase_susp = 4'h3,
    fsq_op_erase_res = 4'h4,
    fsq_op_prog_susp = 4'h5,
    fsq_op_prog_res = 4'h6,
    fsq_op_clear = 4'h7,
    fsq_op_read = 4'h8,
    fsq_op_read_cfg = 4'h9
  } fsq_op_t;
  // Main sequencer states, one-hot
  typedef enum logic [7:0] {
    fsq_idle = 8'h01,
    fsq_write = 8'h02,
    fsq_read = 8'h04,
    fsq_poll = 8'h08,
    fsq_buf_poll = 8'h10,
    fsq_buf_load = 8'h20,
    fsq_done = 8'h40,
    fsq_wait_susp = 8'h80
  } fsq_state_t;
endpackage : fsq_pkg

/* verilog/fsq_bus_cycle.sv */
// One asynchronous flash bus cycle, write or read, timed by a counter of mclk cycles
`timescale 1ns/1ps
`include "fsq_defs.svh"
module fsq_bus_cycle #(
  parameter int AW = 24,
  parameter int PULSE = `FSQ_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic [AW-1:0] fl_addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  // ----------------------------------------------------------------
  // Cycle timer and strobes
  // ----------------------------------------------------------------
  logic [7:0] cnt, next_cnt; // Cycles left in strobe phase
  logic [1:0] ph, next_ph; // 0 idle, 1 strobe, 2 recovery
  logic wr, next_wr; // Current cycle is a write
  logic [15:0] next_rdata;
  logic [AW-1:0] next_fl_addr;
  logic [15:0] next_dq_out;
  logic next_done;
  // Next values of the cycle
  always_comb begin
    next_cnt = cnt;
    next_ph = ph;
    next_wr = wr;
    next_rdata = rdata;
    next_fl_addr = fl_addr;
    next_dq_out = dq_out;
    next_done = 1'b0;
    case (ph)
      2'd0: begin
        if (start) begin
          next_ph = 2'd1;
          next_wr = is_write;
          next_fl_addr = addr;
          next_dq_out = wdata;
          next_cnt = 8'(PULSE);
        end
      end
      2'd1: begin
        // Data captured on the rising write enable, read sampled at end
        if (cnt == 8'h01) begin
          next_ph = 2'd2;
          if (!wr) next_rdata = dq_in;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: begin
        next_ph = 2'd0;
        next_done = 1'b1;
      end
    endcase
  end
  // Register cycle state and pins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
      ph <= 2'd0;
      wr <= 1'b0;
      rdata <= 16'h0000;
      fl_addr <= '0;
      dq_out <= 16'h0000;
      done <= 1'b0;
      busy <= 1'b0;
      dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end else begin
      cnt <= next_cnt;
      ph <= next_ph;
      wr <= next_wr;
      rdata <= next_rdata;
      fl_addr <= next_fl_addr;
      dq_out <= next_dq_out;
      done <= next_done;
      busy <= (next_ph != 2'd0);
      dq_oe <= (next_ph != 2'd0) && next_wr;
      fl_ce_n <= (next_ph != 2'd1);
      fl_we_n <= !((next_ph == 2'd1) && next_wr);
      fl_oe_n <= !((next_ph == 2'd1) && !next_wr);
    end
  end
endmodule : fsq_bus_cycle

/* verilog/fsq_host.sv */
// Host controller that sequences program, buffer and suspend commands to a flash
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "fsq_defs.svh"
module fsq_host #(
  parameter int AW = 24,
  parameter int BUF_WORDS = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [AW-1:0] fl_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  input wire logic status_pin
);
  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  logic [AW-1:0] addr_r; // Target address
  logic [15:0] data_r; // Program data, single word
  logic [5:0] count_r; // Buffer word count minus one
  logic [15:0] buf_mem [BUF_WORDS]; // Buffer data staged by software
  logic [5:0] buf_wp; // Staging write pointer
  logic [7:0] fsr; // Last flash status read
  logic [15:0] rd_word; // Last array word read
  logic seq_err; // Host refused the request
  fsq_pkg::fsq_state_t st, next_st;
  fsq_pkg::fsq_op_t op, next_op;
  logic [2:0] step, next_step; // Position in a command sequence
  logic [5:0] idx, next_idx; // Buffer word index
  logic erase_susp, prog_susp, nested_prog; // Tracked suspend state
  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  logic bc_start, bc_wr, bc_busy, bc_done;
  logic [AW-1:0] bc_addr;
  logic [15:0] bc_wdata, bc_rdata;
  logic sts_s1, sts_s2, sts_s3; // Status pin synchroniser
  logic sts_ready; // Filtered status pin level
  logic bc_wr_q; // Last bus cycle was a write
  logic susp_pend; // Program suspend waiting for the next poll result
  fsq_bus_cycle #(.AW(AW)) u_cyc (
    .mclk(mclk), .rstn(rstn), .start(bc_start), .is_write(bc_wr),
    .addr(bc_addr), .wdata(bc_wdata), .dq_in(dq_in), .busy(bc_busy),
    .done(bc_done), .rdata(bc_rdata), .fl_addr(fl_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n)
  );
  // Block boundary check for a buffered write
  // Addresses count 16-bit words, so a 128KB block starts at bit 16
  function automatic logic fsq_crosses(input logic [AW-1:0] a, input logic [5:0] n);
    logic [AW:0] last;
    last = {1'b0, a} + {{(AW-5){1'b0}}, n};
    return last[AW:16] != {1'b0, a[AW-1:16]};
  endfunction : fsq_crosses
  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  logic go; // Software started an operation
  logic [3:0] req;
  assign go = reg_wr && (reg_addr == `FSQ_REG_CMD) && st == fsq_pkg::fsq_idle;
  assign req = reg_wdata[3:0];
  logic pend_set; // Program suspend written while a program is polled
  assign pend_set = reg_wr && (reg_addr == `FSQ_REG_CMD) && st == fsq_pkg::fsq_poll
                    && fsq_pkg::fsq_op_t'(req) == fsq_pkg::fsq_op_prog_susp
                    && (op == fsq_pkg::fsq_op_program || op == fsq_pkg::fsq_op_buffer);
  always_comb begin
    next_st = st;
    next_op = op;
    next_step = step;
    next_idx = idx;
    bc_start = 1'b0;
    bc_wr = 1'b1;
    bc_addr = addr_r;
    bc_wdata = 16'h0000;
    case (st)
      fsq_pkg::fsq_idle: begin
        if (go) begin
          next_op = fsq_pkg::fsq_op_t'(req);
          next_step = 3'd0;
          next_idx = 6'd0;
          next_st = fsq_pkg::fsq_write;
        end
      end
      fsq_pkg::fsq_write: begin
        if (!bc_busy && !bc_done) begin
          bc_start = 1'b1;
          case (op)
            fsq_pkg::fsq_op_program: bc_wdata = (step == 3'd0) ? {8'h00, `FSQ_CMD_PROGRAM}
                                                : data_r;
            fsq_pkg::fsq_op_buffer: begin
              case (step)
                3'd0: bc_wdata = {8'h00, `FSQ_CMD_BUF_SETUP};
                3'd1: bc_wdata = {10'h000, count_r};
                3'd2: begin
                  bc_addr = addr_r + AW'(idx);
                  bc_wdata = buf_mem[idx[4:0]];
                end
                default: bc_wdata = {8'h00, `FSQ_CMD_CONFIRM};
              endcase
            end
            fsq_pkg::fsq_op_erase_susp, fsq_pkg::fsq_op_prog_susp:
              bc_wdata = {8'h00, `FSQ_CMD_SUSPEND};
            fsq_pkg::fsq_op_erase_res, fsq_pkg::fsq_op_prog_res:
              bc_wdata = {8'h00, `FSQ_CMD_RESUME};
            fsq_pkg::fsq_op_clear: bc_wdata = {8'h00, `FSQ_CMD_CLEAR_STATUS};
            fsq_pkg::fsq_op_read_cfg: bc_wdata = {8'h00, `FSQ_CMD_SET_READ_CFG};
            default: bc_wdata = {8'h00, `FSQ_CMD_READ_ARRAY};
          endcase
        end
        if (bc_done) begin
          next_st = fsq_pkg::fsq_read;
          case (op)
            fsq_pkg::fsq_op_program: begin
              next_step = step + 3'd1;
              next_st = (step == 3'd0) ? fsq_pkg::fsq_write : fsq_pkg::fsq_poll;
            end
            fsq_pkg::fsq_op_buffer: begin
              case (step)
                3'd0: next_st = fsq_pkg::fsq_buf_poll;
                3'd1: next_step = 3'd2;
                3'd2: next_idx = idx + 6'd1;
                default: next_st = fsq_pkg::fsq_poll;
              endcase
              if (step == 3'd1) next_st = fsq_pkg::fsq_write;
              if (step == 3'd2) begin
                next_st = fsq_pkg::fsq_write;
                if (idx == count_r) next_step = 3'd3;
              end
            end
            fsq_pkg::fsq_op_erase_susp, fsq_pkg::fsq_op_prog_susp:
              next_st = fsq_pkg::fsq_wait_susp;
            fsq_pkg::fsq_op_erase_res, fsq_pkg::fsq_op_prog_res:
              next_st = fsq_pkg::fsq_poll;
            fsq_pkg::fsq_op_clear, fsq_pkg::fsq_op_read_cfg: next_st = fsq_pkg::fsq_done;
            default: next_st = fsq_pkg::fsq_read;
          endcase
        end
      end
      fsq_pkg::fsq_read, fsq_pkg::fsq_poll, fsq_pkg::fsq_buf_poll,
      fsq_pkg::fsq_wait_susp: begin
        bc_wr = 1'b0;
        if (!bc_busy && !bc_done) bc_start = 1'b1;
        if (bc_done) begin
          case (st)
            fsq_pkg::fsq_buf_poll: begin
              // Retry setup while buffer unavailable
              next_st = fsq_pkg::fsq_write;
              next_step = bc_rdata[`FSQ_XSR_BUF_AVAIL] ? 3'd1 : 3'd0;
            end
            fsq_pkg::fsq_poll: begin
              if (bc_rdata[`FSQ_SR_READY]) begin
                next_st = fsq_pkg::fsq_done;
              end else if (susp_pend) begin
                // Program still running: send the suspend asked for meanwhile
                next_op = fsq_pkg::fsq_op_prog_susp;
                next_st = fsq_pkg::fsq_write;
              end
            end
            fsq_pkg::fsq_wait_susp:
              if (bc_rdata[`FSQ_SR_READY]) next_st = fsq_pkg::fsq_done;
            default: next_st = fsq_pkg::fsq_done;
          endcase
        end
      end
      default: next_st = fsq_pkg::fsq_idle;
    endcase
  end
  // ----------------------------------------------------------------
  // Sequencer registers and tracked flash state
  // ----------------------------------------------------------------
  logic refuse; // Request not legal in current flash state
  always_comb begin
    case (fsq_pkg::fsq_op_t'(req))
      fsq_pkg::fsq_op_erase_res: refuse = !erase_susp || nested_prog;
      fsq_pkg::fsq_op_prog_res: refuse = !prog_susp;
      fsq_pkg::fsq_op_buffer, fsq_pkg::fsq_op_program:
        refuse = prog_susp || fsr[`FSQ_SR_PROG_ERR] || fsr[`FSQ_SR_ERASE_ERR]
                 || fsq_crosses(addr_r, count_r);
      fsq_pkg::fsq_op_none: refuse = 1'b1;
      default: refuse = 1'b0;
    endcase
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= fsq_pkg::fsq_idle;
      op <= fsq_pkg::fsq_op_none;
      step <= 3'd0;
      idx <= 6'd0;
      addr_r <= '0;
      data_r <= 16'h0000;
      count_r <= 6'd0;
      buf_wp <= 6'd0;
      fsr <= 8'h80;
      rd_word <= 16'h0000;
      seq_err <= 1'b0;
      erase_susp <= 1'b0;
      prog_susp <= 1'b0;
      nested_prog <= 1'b0;
      susp_pend <= 1'b0;
      reg_rdata <= 16'h0000;
      sts_s1 <= 1'b1;
      sts_s2 <= 1'b1;
      sts_s3 <= 1'b1;
      sts_ready <= 1'b1;
    end else begin
      st <= (go && refuse) ? fsq_pkg::fsq_idle : next_st;
      op <= next_op;
      step <= next_step;
      idx <= next_idx;
      sts_s1 <= status_pin;
      sts_s2 <= sts_s1;
      sts_s3 <= sts_s2;
      if (sts_s2 == sts_s3) sts_ready <= sts_s3;
      if (go) seq_err <= refuse;
      // Suspend request only lives while a program is polled
      if (st != fsq_pkg::fsq_poll) susp_pend <= 1'b0;
      else if (pend_set) susp_pend <= 1'b1;
      if (go && !refuse && fsq_pkg::fsq_op_t'(req) == fsq_pkg::fsq_op_program)
        nested_prog <= erase_susp;
      if (reg_wr && reg_addr == `FSQ_REG_ADDR) addr_r <= AW'(reg_wdata);
      if (reg_wr && reg_addr == `FSQ_REG_DATA) begin
        data_r <= reg_wdata;
        buf_mem[buf_wp[4:0]] <= reg_wdata;
        buf_wp <= buf_wp + 6'd1;
      end
      if (reg_wr && reg_addr == `FSQ_REG_COUNT) begin
        count_r <= reg_wdata[5:0];
        buf_wp <= 6'd0;
      end
      if (bc_done && !bc_wr_q) begin
        if (st == fsq_pkg::fsq_read) rd_word <= bc_rdata;
        else if (st != fsq_pkg::fsq_buf_poll && bc_rdata[`FSQ_SR_READY])
          fsr <= bc_rdata[7:0];
        else if (st != fsq_pkg::fsq_buf_poll) fsr[`FSQ_SR_READY] <= 1'b0;
      end
      if (next_st == fsq_pkg::fsq_done) begin
        case (op)
          fsq_pkg::fsq_op_erase_susp: erase_susp <= 1'b1;
          fsq_pkg::fsq_op_prog_susp: prog_susp <= 1'b1;
          fsq_pkg::fsq_op_erase_res: erase_susp <= 1'b0;
          fsq_pkg::fsq_op_prog_res: begin
            // Resumed program polled to its end, so any nesting is over
            prog_susp <= 1'b0;
            nested_prog <= 1'b0;
          end
          fsq_pkg::fsq_op_program, fsq_pkg::fsq_op_buffer: nested_prog <= 1'b0;
          fsq_pkg::fsq_op_clear: fsr[5:1] <= 5'h00;
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `FSQ_REG_STATUS: reg_rdata <= {7'h00, sts_ready, nested_prog, prog_susp,
                                         erase_susp, seq_err, st[7:4] != 4'h0 || st[3:1] != 3'h0,
                                         3'h0};
          `FSQ_REG_FLASH_SR: reg_rdata <= {8'h00, fsr};
          `FSQ_REG_RDATA: reg_rdata <= rd_word;
          `FSQ_REG_ADDR: reg_rdata <= 16'(addr_r);
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
  // Direction of the last bus cycle, for classifying its data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) bc_wr_q <= 1'b1;
    else if (bc_start) bc_wr_q <= bc_wr;
  end
endmodule : fsq_host

/* test/fsq_host_checker.sv */
// Bus-cycle checker for the flash pins of the host controller
`timescale 1ns/1ps
module fsq_host_checker #(
  parameter int AW = 24,
  parameter int BUF_WORDS = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [AW-1:0] fl_addr,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic status_pin
);
  // ----------------------------------------------------------------
  // Strobe framing on the flash pins
  // ----------------------------------------------------------------
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_strobe_excl: assert property (fl_we_n || fl_oe_n)
    else $error("write and read strobes overlap");
  a_strobe_in_ce: assert property (!(fl_we_n && fl_oe_n) |-> !fl_ce_n)
    else $error("strobe outside chip select");
  a_write_len: assert property ($fell(fl_we_n) |-> !fl_we_n [*2] ##1 fl_we_n)
    else $error("write pulse not two cycles");
  a_read_len: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*2] ##1 fl_oe_n)
    else $error("read pulse not two cycles");
  a_write_drive: assert property (!fl_we_n |-> dq_oe)
    else $error("data not driven in write");
  a_read_float: assert property (!fl_oe_n |-> !dq_oe)
    else $error("data driven during read");
  a_write_hold: assert property (!fl_we_n && $past(!fl_we_n) |->
    $stable(dq_out) && $stable(fl_addr)) else $error("write data moved");
  a_recover_gap: assert property ($rose(fl_we_n) || $rose(fl_oe_n) |->
    fl_ce_n && fl_we_n && fl_oe_n) else $error("no recovery clock");
  // Main scenarios seen
  c_write: cover property ($fell(fl_we_n));
  c_read: cover property ($fell(fl_oe_n));
  c_busy_pin: cover property ($fell(status_pin));
endmodule : fsq_host_checker

bind fsq_host fsq_host_checker #(.AW(AW), .BUF_WORDS(BUF_WORDS)) u_fsq_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe(dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n), .status_pin(status_pin));

/* test/fsq_flash_model.sv */
// Behavioural flash device answering the controller's bus cycles
`timescale 1ns/1ps
module fsq_flash_model #(
  parameter int AW = 24,
  parameter int T_PROG = 200,
  parameter int T_ERASE = 400,
  parameter int T_SUSP = 4
) (
  input wire logic [AW-1:0] fl_addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  output logic [15:0] dq_in,
  output logic status_pin,
  input wire logic erase_go,
  input wire logic program_enable_supply_low,
  input wire logic locked
);
  logic [15:0] mem [0:1023]; // Array words, erased to ones
  logic [15:0] ld; // Data of last write cycle
  logic [AW-1:0] la; // Address of last write cycle
  logic [1:0] mode = 2'd0; // 0 array, 1 status, 2 buffer status
  int phase = 0; // 0 cmd, 1 word, 2 count, 3 buffer data, 4 confirm
  int left = 0, prog_left = 0, erase_left = 0, lat = 0;
  logic esusp = 1'b0, psusp = 1'b0, e5 = 1'b0, e4 = 1'b0, e3 = 1'b0, e1 = 1'b0;
  logic free = 1'b0, retry = 1'b1, pat = 1'b0;
  logic [AW-17:0] blk = '0; // Block of the buffer being loaded
  logic busy;
  assign busy = (prog_left > 0 && !psusp) || (erase_left > 0 && !esusp) || lat > 0;
  assign status_pin = !busy;
  // Undriven lines toggle; low status bits float while busy
  assign dq_in = (fl_ce_n || fl_oe_n) ? {8{pat, !pat}} : (mode == 2'd0) ? mem[fl_addr[9:0]]
    : (mode == 2'd2) ? {8'h00, free, {7{pat}}}
    : busy ? {9'h000, {7{pat}}} : {8'h00, 1'b1, esusp, e5, e4, e3, psusp, e1, 1'b0};
  initial for (int i = 0; i < 1024; i++) mem[i] = 16'hffff;
  always @(posedge erase_go) erase_left = T_ERASE;
  // Internal timer: suspend latency, then program or erase progress
  // Ticks fall between clock edges, so the controller never samples a change
  initial #25 forever #50 begin
    pat = !pat;
    if (lat > 0) begin
      lat = lat - 1;
      if (lat == 0 && prog_left > 0) psusp = 1'b1;
      else if (lat == 0) esusp = 1'b1;
    end else if (prog_left > 0 && !psusp) prog_left = prog_left - 1;
    else if (erase_left > 0 && !esusp) erase_left = erase_left - 1;
  end
  task automatic start_prog();
    if (program_enable_supply_low) {e4, e3} = 2'b11;
    else if (locked) {e4, e1} = 2'b11;
    else prog_left = T_PROG;
  endtask : start_prog
  always @(negedge fl_we_n) begin
    #1;
    la = fl_addr;
    ld = dq_out;
  end
  // Command decode on the rising write strobe
  always @(posedge fl_we_n) begin
    if (phase == 3 && la[AW-1:16] != blk) begin
      {e5, e4} = 2'b11;
      phase = 0;
    end else if (phase == 1 || phase == 3) begin
      if (!program_enable_supply_low && !locked) mem[la[9:0]] = mem[la[9:0]] & ld;
      left = left - 1;
      if (phase == 1) start_prog();
      phase = (phase == 3 && left > 0) ? 3 : (phase == 3) ? 4 : 0;
    end else if (phase == 2) begin
      left = ld[4:0] + 1;
      blk = la[AW-1:16];
      phase = 3;
    end else if (phase == 4) begin
      phase = 0;
      mode = 2'd1;
      if (ld[7:0] == 8'hd0) start_prog();
      else {e5, e4} = 2'b11;
    end else case (ld[7:0])
      8'hff: mode = 2'd0;
      8'h70: mode = 2'd1;
      8'h50: if (!busy) {e5, e4, e3, e1} = 4'h0;
      8'h40, 8'h10: begin
        mode = 2'd1;
        if (!psusp) phase = 1;
      end
      8'he8: begin
        mode = 2'd2;
        free = !retry && !e4 && !e5 && !psusp;
        retry = !retry;
        if (free) phase = 2;
      end
      8'hb0: begin
        mode = 2'd1;
        if (busy && lat == 0) lat = T_SUSP;
      end
      8'hd0: begin
        mode = 2'd1;
        if (psusp) psusp = 1'b0;
        else if (esusp && prog_left == 0) esusp = 1'b0;
      end
      default: ;
    endcase
  end
endmodule : fsq_flash_model

/* test/tb_fsq_host.sv */
// Self-checking bench for the flash host controller against a flash model
`timescale 1ns/1ps
`include "fsq_defs.svh"
module tb_fsq_host;
  logic mclk = 1'b0; // 10 MHz clock
  logic rstn = 1'b0; // Reset, active low
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, dq_in, dq_out, v;
  logic [23:0] fl_addr;
  logic dq_oe, fl_ce_n, fl_we_n, fl_oe_n, status_pin;
  logic erase_go = 1'b0, program_enable_supply_low = 1'b0, locked = 1'b0; // Model controls
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #50 mclk = ~mclk;
  fsq_host #(.AW(24), .BUF_WORDS(32)) DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_addr(fl_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .status_pin(status_pin));
  fsq_flash_model #(.AW(24)) u_flash (.fl_addr(fl_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .dq_in(dq_in),
    .status_pin(status_pin), .erase_go(erase_go), .program_enable_supply_low(program_enable_supply_low), .locked(locked));
  // ----------------------------------------------------------------
  // Register port tasks and compares
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic sts(input logic [15:0] m, input logic [15:0] e);
    rd(`FSQ_REG_STATUS, v);
    chk(v & m, e);
  endtask : sts
  task automatic fsr(input logic [7:0] e);
    rd(`FSQ_REG_FLASH_SR, v);
    chk({8'h00, v[7:0]}, {8'h00, e});
  endtask : fsr
  task automatic idle();
    for (int k = 0; k < 3000; k++) begin
      rd(`FSQ_REG_STATUS, v);
      if (v[3] === 1'b0) break;
    end
    chk(v & 16'h0008, 16'h0000);
  endtask : idle
  task automatic op(input logic [3:0] code);
    wr(`FSQ_REG_CMD, {12'h000, code});
    idle();
  endtask : op
  task automatic stg(input logic [15:0] a, input int n, input logic [15:0] d);
    wr(`FSQ_REG_COUNT, 16'(n - 1));
    for (int i = 0; i < n; i++) wr(`FSQ_REG_DATA, d + 16'(i));
    wr(`FSQ_REG_ADDR, a);
  endtask : stg
  task automatic rb(input logic [15:0] a, input logic [15:0] e);
    wr(`FSQ_REG_ADDR, a);
    op(4'h8);
    rd(`FSQ_REG_RDATA, v);
    chk(v, e);
  endtask : rb
  // Cycle ceiling against hangs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_errors++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    chk({12'h000, fl_ce_n, fl_we_n, fl_oe_n, dq_oe}, 16'h000e);
    chk(reg_rdata, 16'h0000);
    rstn <= 1'b1;
    wr(4'hf, 16'h0001); // Unmapped place, no effect
    sts(16'h0018, 16'h0000);
    stg(16'h0010, 1, 16'h1234);
    op(4'h1);
    fsr(8'h80);
    rb(16'h0010, 16'h1234);
    stg(16'h0010, 1, 16'hff00);
    op(4'h1);
    rb(16'h0010, 16'h1200);
    op(4'h9);
    sts(16'h0010, 16'h0000);
    rb(16'h0010, 16'h1200);
    stg(16'h0040, 4, 16'hab00);
    op(4'h2);
    fsr(8'h80);
    rb(16'h0040, 16'hab00);
    stg(16'hfffe, 4, 16'h5500);
    op(4'h2);
    sts(16'h0010, 16'h0010);
    // Supply and lock faults on single and buffered program
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk);
      program_enable_supply_low <= f[0] == 1'b0;
      locked <= f[0] == 1'b1;
      stg(16'h0050, 1, 16'h0000);
      op(f[1] ? 4'h2 : 4'h1);
      fsr(f[0] ? 8'h92 : 8'h98);
      op(4'h2);
      sts(16'h0010, 16'h0010);
      op(4'h7);
      @(posedge mclk);
      program_enable_supply_low <= 1'b0;
      locked <= 1'b0;
      op(4'h1);
      fsr(8'h80);
    end
    // Program suspend and resume
    stg(16'h0080, 1, 16'h00f0);
    wr(`FSQ_REG_CMD, 16'h0001);
    repeat (30) @(posedge mclk);
    op(4'h5);
    sts(16'h0050, 16'h0040);
    fsr(8'h84);
    rb(16'h0010, 16'h1200);
    op(4'h6);
    sts(16'h0050, 16'h0000);
    fsr(8'h80);
    rb(16'h0080, 16'h00f0);
    op(4'h6);
    sts(16'h0010, 16'h0010);
    // Erase suspend, nested program, resume
    @(posedge mclk);
    erase_go <= 1'b1;
    op(4'h3);
    sts(16'h0020, 16'h0020);
    fsr(8'hc0);
    rb(16'h0040, 16'hab00);
    stg(16'h00a0, 1, 16'h0f0f);
    wr(`FSQ_REG_CMD, 16'h0001);
    repeat (30) @(posedge mclk);
    sts(16'h01a0, 16'h00a0);
    wr(`FSQ_REG_CMD, 16'h0004);
    sts(16'h0030, 16'h0020);
    idle();
    fsr(8'hc0);
    op(4'h4);
    sts(16'h0030, 16'h0000);
    op(4'h4);
    sts(16'h0010, 16'h0010);
    finish_test();
  end
endmodule : tb_fsq_host
